// File: rtl/scgc_consts.vh
// Notes on behaviour
// [RQ1] capture mask when primary released, secondary held
// [RQ2] mask shifts into disable register, set disables
// [RQ3] all-zero mask leaves every clock running
// [RQ4] all-one mask holds every clock high
// [RQ5] strap high plus D3hot: B2, clocks low
// [RQ6] strap low: D3hot leaves clocks alone
// [RQ7] fast strap selects 66MHz, else 33MHz
// [RQ8] board straps mode bits to normal only
// [RQ9] test mode: shared pin is scan enable
// [RQ10] each GPIO input-only or bidirectional per bit
// [RQ11] ten outputs follow primary clock, one fed back
// [RQ12] mask uses GPIO pins with serial input
// [RQ13] one bit per output, first to zero
`ifndef SCGC_CONSTS_VH
`define SCGC_CONSTS_VH

// register byte addresses
`define SCGC_ADDR_CLK_DISABLE 8'h00
`define SCGC_ADDR_POWER_STATE 8'h04
`define SCGC_ADDR_GPIO_OE     8'h08
`define SCGC_ADDR_GPIO_OUT    8'h0C
`define SCGC_ADDR_STATUS      8'h10

// power state field value for D3hot
`define SCGC_PSTATE_D3HOT     2'h3
// normal operation strap code {bit1, bit0}
`define SCGC_MODE_NORMAL      2'h1

// status bit positions
`define SCGC_ST_GPIO_LSB      0
`define SCGC_ST_FAST          4
`define SCGC_ST_NORMAL        5
`define SCGC_ST_TEST          6
`define SCGC_ST_BUSY          7
`define SCGC_ST_DONE          8
`define SCGC_ST_FEEDBACK      9

// GPIO pins borrowed while the mask is captured
`define SCGC_GPIO_LOAD        0
`define SCGC_GPIO_STROBE      1

// synchroniser bit positions
`define SCGC_SY_PRST          0
`define SCGC_SY_SRST          1
`define SCGC_SY_MASK          2
`define SCGC_SY_BPC           3
`define SCGC_SY_FAST          4
`define SCGC_SY_MS0           5
`define SCGC_SY_MS1           6
`define SCGC_SY_TEST          7
`define SCGC_SY_FB            8
`define SCGC_SY_GPIO_LSB      9

`endif

// File: rtl/scgc_sync3.v
`timescale 1ns/1ps
// three-stage pin synchroniser with agreement filter
module scgc_sync3 #(
  parameter WIDTH = 1
) (
  input  wire             clock,
  input  wire             srst,
  input  wire [WIDTH-1:0] pin,
  output wire [WIDTH-1:0] level
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg stage1;  // metastable stage, read only by stage2
      reg stage2;
      reg stage3;
      reg filtered; // settled level

      // a change counts only once stages two and three agree
      always @(posedge clock) begin
        if (srst) begin
          stage1   <= 1'b0;
          stage2   <= 1'b0;
          stage3   <= 1'b0;
          filtered <= 1'b0;
        end else begin
          stage1 <= pin[i];
          stage2 <= stage1;
          stage3 <= stage2;
          if (stage2 == stage3) begin
            filtered <= stage3;
          end
        end
      end
      assign level[i] = filtered;
    end
  endgenerate

endmodule

// File: rtl/scgc_top.v
`timescale 1ns/1ps
`include "scgc_consts.vh"
// secondary clock gating and strap control
module scgc_top #(
  parameter NUM_CLK  = 10,
  parameter NUM_GPIO = 4
) (
  input  wire                clock,
  input  wire                srst,
  // register port
  input  wire [7:0]          reg_addr,
  input  wire [31:0]         reg_wdata,
  input  wire                reg_write,
  input  wire                reg_read,
  output reg  [31:0]         reg_rdata,
  // pins
  input  wire                primary_reset_n,
  input  wire                secondary_reset_n,
  input  wire                clock_mask_serial_in,
  input  wire                bus_power_clock_strap,
  input  wire                fast_rate_strap,
  input  wire                mode_sel_bit0,
  input  wire                mode_sel_bit1,
  input  wire                test_mode,
  input  wire                secondary_clock_feedback,
  input  wire [NUM_GPIO-1:0] gpio_in,
  output reg  [NUM_GPIO-1:0] gpio_out,
  output reg  [NUM_GPIO-1:0] gpio_oe,
  output reg  [NUM_CLK-1:0]  secondary_clock_out,
  output reg                 secondary_bus_b2,
  output reg                 rate_66mhz,
  output reg                 scan_shift,
  output reg                 scan_parallel
);

  localparam SYW = `SCGC_SY_GPIO_LSB + NUM_GPIO;
  // capture states
  localparam ST_IDLE = 2'b00;
  localparam ST_CAPT = 2'b01;
  localparam ST_DONE = 2'b10;

  wire [SYW-1:0]      sy;            // settled pin levels
  reg  [NUM_CLK-1:0]  clk_disable;   // set bit stops an output high
  reg  [1:0]          power_state;   // software power state
  reg  [NUM_GPIO-1:0] gpio_oe_reg;   // per-pin direction
  reg  [NUM_GPIO-1:0] gpio_out_reg;  // per-pin drive value
  reg  [1:0]          cap_state;
  reg  [3:0]          cap_count;     // bits taken so far
  reg                 clk_phase;     // shared secondary phase
  reg                 fb_prev;       // last settled feedback level
  reg                 fb_seen;       // feedback toggled since read
  reg  [1:0]          next_cap_state;
  reg  [31:0]         next_rdata;

  wire prst_released = sy[`SCGC_SY_PRST];
  wire srst_held     = ~sy[`SCGC_SY_SRST];
  wire mode_normal   = ({sy[`SCGC_SY_MS1], sy[`SCGC_SY_MS0]} == `SCGC_MODE_NORMAL);
  wire capturing     = (cap_state == ST_CAPT);
  wire last_bit      = (cap_count == NUM_CLK[3:0] - 4'h1);
  // [RQ5] strap gates the D3hot stop
  wire force_low     = sy[`SCGC_SY_BPC] && (power_state == `SCGC_PSTATE_D3HOT);
  wire fb_edge       = sy[`SCGC_SY_FB] ^ fb_prev;

  // address decode shared by read and write paths
  function hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  // all pins from outside pass the synchroniser
  scgc_sync3 #(
    .WIDTH (SYW)
  ) u_sync (
    .clock (clock),
    .srst  (srst),
    .pin   ({gpio_in, secondary_clock_feedback, test_mode, mode_sel_bit1, mode_sel_bit0,
             fast_rate_strap, bus_power_clock_strap, clock_mask_serial_in,
             secondary_reset_n, primary_reset_n}),
    .level (sy)
  );

  // capture sequencing
  always @* begin
    next_cap_state = cap_state;
    case (cap_state)
      ST_IDLE: begin
        // [RQ1] start in reset window
        if (prst_released && srst_held) begin
          next_cap_state = ST_CAPT;
        end
      end
      ST_CAPT: begin
        if (!prst_released) begin
          next_cap_state = ST_IDLE;   // primary reset again: restart
        end else if (last_bit) begin
          next_cap_state = ST_DONE;
        end
      end
      ST_DONE: begin
        // rearm only once the window has closed
        if (!srst_held || !prst_released) begin
          next_cap_state = ST_IDLE;
        end
      end
      default: begin
        next_cap_state = ST_IDLE;
      end
    endcase
  end

  // state, bit counter and disable mask
  always @(posedge clock) begin
    if (srst) begin
      cap_state   <= ST_IDLE;
      cap_count   <= 4'h0;
      clk_disable <= {NUM_CLK{1'b0}};
    end else begin
      cap_state <= next_cap_state;
      if (capturing) begin
        cap_count <= cap_count + 4'h1;
        // [RQ13] first bit lands at output zero
        clk_disable <= {sy[`SCGC_SY_MASK], clk_disable[NUM_CLK-1:1]};
      end else begin
        cap_count <= 4'h0;
        // software path, the alternative to the serial mask
        if (reg_write && hit(reg_addr, `SCGC_ADDR_CLK_DISABLE)) begin
          clk_disable <= reg_wdata[NUM_CLK-1:0];
        end
      end
    end
  end

  // software control registers
  always @(posedge clock) begin
    if (srst) begin
      power_state  <= 2'h0;
      gpio_oe_reg  <= {NUM_GPIO{1'b0}};
      gpio_out_reg <= {NUM_GPIO{1'b0}};
    end else if (reg_write) begin
      if (hit(reg_addr, `SCGC_ADDR_POWER_STATE)) begin
        power_state <= reg_wdata[1:0];
      end
      if (hit(reg_addr, `SCGC_ADDR_GPIO_OE)) begin
        gpio_oe_reg <= reg_wdata[NUM_GPIO-1:0];
      end
      if (hit(reg_addr, `SCGC_ADDR_GPIO_OUT)) begin
        gpio_out_reg <= reg_wdata[NUM_GPIO-1:0];
      end
    end
  end

  // secondary clocks: one phase toggled every cycle keeps all ten aligned
  always @(posedge clock) begin
    if (srst) begin
      clk_phase           <= 1'b0;
      secondary_clock_out <= {NUM_CLK{1'b0}};
      secondary_bus_b2    <= 1'b0;
    end else begin
      clk_phase        <= ~clk_phase;
      secondary_bus_b2 <= force_low;
      if (force_low) begin
        // [RQ5] hold clocks at zero
        secondary_clock_out <= {NUM_CLK{1'b0}};
      end else begin
        // [RQ2] [RQ3] [RQ4] [RQ6] [RQ11] disabled bits high
        secondary_clock_out <= clk_disable | {NUM_CLK{~clk_phase}};
      end
    end
  end

  // strap decode; scan decode only meaningful in test mode
  always @(posedge clock) begin
    if (srst) begin
      rate_66mhz    <= 1'b0;
      scan_shift    <= 1'b0;
      scan_parallel <= 1'b0;
    end else begin
      // [RQ7] fast strap in normal use
      rate_66mhz <= sy[`SCGC_SY_FAST] && !sy[`SCGC_SY_TEST];
      // [RQ9] shared pin as scan enable
      scan_shift    <= sy[`SCGC_SY_TEST] && !sy[`SCGC_SY_FAST];
      scan_parallel <= sy[`SCGC_SY_TEST] && sy[`SCGC_SY_FAST];
    end
  end

  // gpio drive; two pins are borrowed to frame the serial mask
  always @(posedge clock) begin
    if (srst) begin
      gpio_out <= {NUM_GPIO{1'b0}};
      gpio_oe  <= {NUM_GPIO{1'b0}};
    end else begin
      // [RQ10] direction from enable bits
      gpio_out <= gpio_out_reg;
      gpio_oe  <= gpio_oe_reg;
      if (next_cap_state == ST_CAPT) begin
        // [RQ12] load and strobe framing
        gpio_out[`SCGC_GPIO_LOAD]   <= 1'b1;
        gpio_oe[`SCGC_GPIO_LOAD]    <= 1'b1;
        gpio_out[`SCGC_GPIO_STROBE] <= ~gpio_out[`SCGC_GPIO_STROBE];
        gpio_oe[`SCGC_GPIO_STROBE]  <= 1'b1;
      end
    end
  end

  // feedback watch: set wins over the clear by status read
  always @(posedge clock) begin
    if (srst) begin
      fb_prev <= 1'b0;
      fb_seen <= 1'b0;
    end else begin
      fb_prev <= sy[`SCGC_SY_FB];
      if (fb_edge) begin
        fb_seen <= 1'b1;
      end else if (reg_read && hit(reg_addr, `SCGC_ADDR_STATUS)) begin
        fb_seen <= 1'b0;
      end
    end
  end

  // read mux, unmapped reads return zero
  always @* begin
    next_rdata = 32'h0000_0000;
    if (hit(reg_addr, `SCGC_ADDR_CLK_DISABLE)) begin
      next_rdata[NUM_CLK-1:0] = clk_disable;
    end else if (hit(reg_addr, `SCGC_ADDR_POWER_STATE)) begin
      next_rdata[1:0] = power_state;
    end else if (hit(reg_addr, `SCGC_ADDR_GPIO_OE)) begin
      next_rdata[NUM_GPIO-1:0] = gpio_oe_reg;
    end else if (hit(reg_addr, `SCGC_ADDR_GPIO_OUT)) begin
      next_rdata[NUM_GPIO-1:0] = gpio_out_reg;
    end else if (hit(reg_addr, `SCGC_ADDR_STATUS)) begin
      next_rdata[`SCGC_ST_GPIO_LSB +: NUM_GPIO] = sy[`SCGC_SY_GPIO_LSB +: NUM_GPIO];
      next_rdata[`SCGC_ST_FAST]     = sy[`SCGC_SY_FAST];
      // [RQ8] reserved codes show as not normal
      next_rdata[`SCGC_ST_NORMAL]   = mode_normal;
      next_rdata[`SCGC_ST_TEST]     = sy[`SCGC_SY_TEST];
      next_rdata[`SCGC_ST_BUSY]     = capturing;
      next_rdata[`SCGC_ST_DONE]     = (cap_state == ST_DONE);
      next_rdata[`SCGC_ST_FEEDBACK] = fb_seen;
    end
  end

  // read data stands only in the cycle after the strobe
  always @(posedge clock) begin
    if (srst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule

// File: tb/scgc_props.sv
`timescale 1ns/1ps
// port-level checks on clock gating and straps
module scgc_top_props #(
  parameter NUM_CLK = 10
) (
  input wire               clock,
  input wire               srst,
  input wire               reg_read,
  input wire [31:0]        reg_rdata,
  input wire               bus_power_clock_strap,
  input wire               fast_rate_strap,
  input wire               mode_sel_bit0,
  input wire               mode_sel_bit1,
  input wire               test_mode,
  input wire [NUM_CLK-1:0] secondary_clock_out,
  input wire               secondary_bus_b2,
  input wire               rate_66mhz,
  input wire               scan_shift,
  input wire               scan_parallel
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // eight steady cycles outlast the pin synchroniser
  sequence s_fast;
    (mode_sel_bit0 && !mode_sel_bit1 && !test_mode && fast_rate_strap)[*8];
  endsequence
  // a running clock seen falling
  sequence s_fall;
    !secondary_bus_b2 && secondary_clock_out[0] ##1 !secondary_bus_b2 && !secondary_clock_out[0];
  endsequence
  chk_b2_clk_low: assert property (secondary_bus_b2 |-> secondary_clock_out == '0)
    else $error("clocks not low in B2");
  chk_strap_no_b2: assert property ((!bus_power_clock_strap)[*8] |-> !secondary_bus_b2)
    else $error("B2 entered with strap low");
  chk_rate_fast: assert property (s_fast |-> rate_66mhz)
    else $error("fast rate not selected");
  chk_rate_slow: assert property ((!fast_rate_strap)[*8] |-> !rate_66mhz)
    else $error("fast rate with strap low");
  chk_test_no_rate: assert property (test_mode[*8] |-> !rate_66mhz)
    else $error("rate strap active in test mode");
  chk_scan_shift: assert property ((test_mode && !fast_rate_strap)[*8] |-> scan_shift && !scan_parallel)
    else $error("scan shift wrong");
  chk_scan_par: assert property ((test_mode && fast_rate_strap)[*8] |-> scan_parallel && !scan_shift)
    else $error("scan parallel wrong");
  chk_clk_toggle: assert property (s_fall |=> secondary_clock_out[0] || secondary_bus_b2)
    else $error("enabled clock stalled");
  chk_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data outside slot");
endmodule
bind scgc_top scgc_top_props #(.NUM_CLK(NUM_CLK)) i_props (.clock, .srst, .reg_read, .reg_rdata,
  .bus_power_clock_strap, .fast_rate_strap, .mode_sel_bit0, .mode_sel_bit1, .test_mode,
  .secondary_clock_out, .secondary_bus_b2, .rate_66mhz, .scan_shift, .scan_parallel);

// File: tb/scgc_board.sv
`timescale 1ns/1ps
// board straps and serial mask source
module scgc_board (
  input  wire clock,
  input  wire go,
  input  wire level,
  output reg  primary_reset_n,
  output reg  secondary_reset_n,
  output reg  clock_mask_serial_in,
  output wire mode_sel_bit0,
  output wire mode_sel_bit1
);
  assign mode_sel_bit0 = 1'b1;
  assign mode_sel_bit1 = 1'b0;
  initial begin
    primary_reset_n = 1'b0;
    secondary_reset_n = 1'b0;
    clock_mask_serial_in = 1'b0;
  end
  // primary freed first, secondary held long
  always @(posedge clock) begin
    if (go) begin
      primary_reset_n <= 1'b0;
      secondary_reset_n <= 1'b0;
      clock_mask_serial_in <= level;
      repeat (6) @(posedge clock);
      primary_reset_n <= 1'b1;
      repeat (40) @(posedge clock);
      secondary_reset_n <= 1'b1;
      // window over: pin no longer meaningful
      clock_mask_serial_in <= ~level;
    end
  end
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  reg         clock = 0, srst = 1, reg_write = 0, reg_read = 0, go = 0, level = 0;
  reg         bus_power_clock_strap = 0, fast_rate_strap = 0, test_mode = 0;
  reg  [7:0]  reg_addr = 0;
  reg  [31:0] reg_wdata = 0, s;
  reg  [3:0]  gpio_ext = 0;
  reg  [9:0]  x;
  wire [31:0] reg_rdata;
  wire [3:0]  gpio_out, gpio_oe;
  wire [9:0]  secondary_clock_out;
  wire        secondary_bus_b2, rate_66mhz, scan_shift, scan_parallel;
  wire        primary_reset_n, secondary_reset_n, clock_mask_serial_in, mode_sel_bit0, mode_sel_bit1;
  // pad level: driver wins where enabled
  wire [3:0]  gpio_pad = (gpio_oe & gpio_out) | (~gpio_oe & gpio_ext);
  integer     err_total = 0, tests_run = 0, i;
  always #10 clock = ~clock;
  scgc_board i_scgc_board (.clock, .go, .level, .primary_reset_n, .secondary_reset_n,
    .clock_mask_serial_in, .mode_sel_bit0, .mode_sel_bit1);
  scgc_top i_scgc_top (.clock, .srst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .primary_reset_n, .secondary_reset_n, .clock_mask_serial_in, .bus_power_clock_strap,
    .fast_rate_strap, .mode_sel_bit0, .mode_sel_bit1, .test_mode,
    .secondary_clock_feedback(secondary_clock_out[0]), .gpio_in(gpio_pad), .gpio_out, .gpio_oe,
    .secondary_clock_out, .secondary_bus_b2, .rate_66mhz, .scan_shift, .scan_parallel);
  task cyc(input integer n);
    begin repeat (n) @(posedge clock); #1; end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clock) begin reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1; end
      @(posedge clock) reg_write <= 1'b0;
    end
  endtask
  // data stands only in the slot after the strobe
  task rd(input [7:0] a, output [31:0] d);
    begin
      @(posedge clock) begin reg_addr <= a; reg_read <= 1'b1; end
      @(posedge clock) reg_read <= 1'b0;
      #1 d = reg_rdata;
    end
  endtask
  task summarize;
    begin
      $display("mismatches %0d of %0d checks", err_total, tests_run);
      if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // constant mask pin through one reset window
  task t_mask(input lv);
    begin
      @(posedge clock) begin go <= 1'b1; level <= lv; end
      @(posedge clock) go <= 1'b0;
      for (i = 0; i < 40 && gpio_oe[0] !== 1'b1; i++) cyc(1);
      `CHK(gpio_oe[0], 1'b1)
      if (gpio_oe[0] !== 1'b1) summarize;
      `CHK({gpio_out[0], gpio_oe[1]}, 2'h3)
      // a software write inside the capture must be refused
      wr(8'h00, lv ? 32'h0 : 32'h3FF);
      cyc(60);
      rd(8'h00, s);
      `CHK(s[9:0], lv ? 10'h3FF : 10'h000)
      x = secondary_clock_out;
      cyc(1);
      `CHK(secondary_clock_out, lv ? 10'h3FF : ~x)
    end
  endtask
  task t_gpio;
    begin
      @(posedge clock) gpio_ext <= 4'h6;
      wr(8'h08, 32'hA);
      wr(8'h0C, 32'h5);
      cyc(8);
      `CHK({gpio_oe, gpio_out}, 8'hA5)
      rd(8'h10, s);
      `CHK(s[3:0], (4'hA & 4'h5) | (~4'hA & 4'h6))
      `CHK(s[8:4], 5'h02)
      rd(8'h20, s);
      `CHK(s, 32'h0)
    end
  endtask
  // software disable: set bits high, clear bits run
  task t_sw;
    begin
      wr(8'h00, 32'h155);
      cyc(3);
      x = secondary_clock_out;
      cyc(1);
      `CHK(secondary_clock_out & 10'h155, 10'h155)
      `CHK(secondary_clock_out ^ x, 10'h2AA)
    end
  endtask
  task t_power(input st);
    begin
      @(posedge clock) bus_power_clock_strap <= st;
      wr(8'h00, 32'h0);
      wr(8'h04, 32'h3);
      cyc(10);
      x = secondary_clock_out;
      cyc(1);
      `CHK({secondary_bus_b2, secondary_clock_out}, st ? 11'h400 : {1'b0, ~x})
      wr(8'h04, 32'h0);
      cyc(10);
      `CHK(secondary_bus_b2, 1'b0)
    end
  endtask
  // every test and rate strap pairing
  task t_rate;
    integer k;
    begin
      for (k = 0; k < 4; k++) begin
        @(posedge clock) {test_mode, fast_rate_strap} <= k[1:0];
        cyc(10);
        `CHK({rate_66mhz, scan_shift, scan_parallel}, {k == 1, k == 2, k == 3})
      end
    end
  endtask
  initial begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    t_mask(1'b1);
    t_mask(1'b0);
    t_gpio;
    t_sw;
    t_power(1'b1);
    t_power(1'b0);
    t_rate;
    summarize;
  end
endmodule
